//--- safe_torque_off_interlock_tb.sv
// Purpose: Self-checking bench for the torque-off interlock
// Assumes: Counts are fixed, so the run covers about 65 scan ticks
// Notes:   Scan tick is shortened; the pulse window keeps its real length
`timescale 1ns/10ps
module safe_torque_off_interlock_tb;
    import stoi_pkg::*;
    // Hang ceiling: all scenarios need about 65000 clocks
    localparam int unsigned LIMIT = 80000;
    // Short scan tick so the 10 tick release and relay paths fit the run
    localparam int unsigned TB_SCAN = 1000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        stop_cmd = 1'b0;
    logic        rel_cmd = 1'b1;
    logic        tpulse = 1'b0;
    logic        clr = 1'b0;
    logic        stop_pin, rel_pin;
    logic        amp, gate, relay, ready, inhibit, fault;
    int unsigned n_errors = 0;
    int unsigned comparisons = 0;
    int unsigned cycles = 0;
    int unsigned n;
    // Free-running 20 MHz clock
    always #25 clk_i = ~clk_i;
    stoi_safety_ctrl stoi_safety_ctrl_inst (
        .stop_cmd_i   (stop_cmd),
        .release_cmd_i(rel_cmd),
        .test_pulse_i (tpulse),
        .stop_pin_o   (stop_pin),
        .release_pin_o(rel_pin)
    );
    stoi_interlock #(
        .SCAN_TICK_CYC(TB_SCAN)
    ) stoi_interlock_inst (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .safe_stop_request_input_i  (stop_pin),
        .power_stage_release_input_i(rel_pin),
        .restart_clear_i            (clr),
        .amp_supply_on_o            (amp),
        .gate_enable_o              (gate),
        .stop_feedback_relay_o      (relay),
        .power_stage_ready_o        (ready),
        .restart_inhibit_o          (inhibit),
        .channel_fault_o            (fault)
    );
    task automatic check_bit(input string name, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask : check_bit
    // Current level of one watched output
    function automatic logic pick(input logic [1:0] sel);
        case (sel)
            2'h0:    return amp;
            2'h1:    return ready;
            2'h2:    return gate;
            default: return relay;
        endcase
    endfunction : pick
    // Bounded wait on amp, ready, gate or relay (sel 0..3) reaching lvl
    task automatic wait_out(input logic [1:0] sel, input logic lvl,
                            input int unsigned lim);
        n = 0;
        while ((pick(sel) !== lvl) && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_out
    task automatic clear_pulse();
        clr = 1'b1;
        repeat (3) @(negedge clk_i);
        clr = 1'b0;
        repeat (5) @(negedge clk_i);
    endtask : clear_pulse
    task automatic t_reset();
        repeat (2) @(negedge clk_i);
        check_bit("amp", 1'b0, amp);
        check_bit("relay", 1'b0, relay);
        check_bit("ready", 1'b0, ready);
        check_bit("inhibit", 1'b1, inhibit);
        check_bit("fault", 1'b0, fault);
        rst_i = 1'b0;
    endtask : t_reset
    task automatic t_power_up();
        wait_out(2'h0, 1'b1, PULSE_CYC + 3 * TB_SCAN);
        check_bit("amp up", 1'b1, amp);
        check_bit("stop delay", 1'b1, n >= TB_SCAN);
        check_bit("ready inhibited", 1'b0, ready);
    endtask : t_power_up
    // A low lasting exactly the pulse window is the longest one ignored
    task automatic t_test_pulse();
        int unsigned drops;
        drops = 0;
        tpulse = 1'b1;
        repeat (PULSE_CYC) @(negedge clk_i);
        tpulse = 1'b0;
        repeat (3 * TB_SCAN) begin
            @(negedge clk_i);
            if (amp !== 1'b1) drops++;
        end
        check_bit("pulse ignored", 1'b1, drops == 0);
    endtask : t_test_pulse
    task automatic t_stop_trip();
        stop_cmd = 1'b1;
        wait_out(2'h0, 1'b0, PULSE_CYC + 3 * TB_SCAN + 10);
        check_bit("amp cut", 1'b0, amp);
        check_bit("trip delay", 1'b1, n >= PULSE_CYC + TB_SCAN);
        repeat (3) @(negedge clk_i);
        check_bit("gate", 1'b0, gate);
        check_bit("inhibit set", 1'b1, inhibit);
        check_bit("ready", 1'b0, ready);
        check_bit("relay one ch", 1'b0, relay);
        check_bit("fault", 1'b0, fault);
        clear_pulse();
        check_bit("clear refused", 1'b1, inhibit);
    endtask : t_stop_trip
    task automatic t_restart();
        stop_cmd = 1'b0;
        wait_out(2'h0, 1'b1, PULSE_CYC + 3 * TB_SCAN);
        check_bit("amp back", 1'b1, amp);
        check_bit("still inhibited", 1'b1, inhibit);
        check_bit("ready held", 1'b0, ready);
        clear_pulse();
        check_bit("inhibit cleared", 1'b0, inhibit);
        wait_out(2'h1, 1'b1, 12 * TB_SCAN);
        check_bit("ready", 1'b1, ready);
        check_bit("gate on", 1'b1, gate);
        check_bit("relay open", 1'b0, relay);
    endtask : t_restart
    // Release low alone: gate cut over one channel, supply and relay stay
    task automatic t_release_trip();
        rel_cmd = 1'b0;
        wait_out(2'h2, 1'b0, PULSE_CYC + 11 * TB_SCAN + 10);
        check_bit("gate cut", 1'b0, gate);
        check_bit("rel delay", 1'b1, n >= PULSE_CYC + 9 * TB_SCAN);
        repeat (3) @(negedge clk_i);
        check_bit("amp one ch", 1'b1, amp);
        check_bit("relay one ch", 1'b0, relay);
        check_bit("ready one ch", 1'b0, ready);
    endtask : t_release_trip
    // Both channels low: relay closes only after its operating delay
    task automatic t_double_trip();
        stop_cmd = 1'b1;
        wait_out(2'h0, 1'b0, PULSE_CYC + 3 * TB_SCAN + 10);
        check_bit("amp cut both", 1'b0, amp);
        check_bit("relay not yet", 1'b0, relay);
        check_bit("inhibit both", 1'b1, inhibit);
        wait_out(2'h3, 1'b1, 11 * TB_SCAN);
        check_bit("relay closed", 1'b1, relay);
        check_bit("relay delay", 1'b1, n >= 9 * TB_SCAN);
    endtask : t_double_trip
    // Both requests lifted: relay opens, restart needs the clear again
    task automatic t_recover();
        stop_cmd = 1'b0;
        rel_cmd  = 1'b1;
        wait_out(2'h3, 1'b0, 3 * TB_SCAN + 10);
        check_bit("relay opens", 1'b0, relay);
        check_bit("amp again", 1'b1, amp);
        check_bit("inhibit held", 1'b1, inhibit);
        check_bit("ready blocked", 1'b0, ready);
        clear_pulse();
        check_bit("inhibit off", 1'b0, inhibit);
        wait_out(2'h1, 1'b1, 12 * TB_SCAN);
        check_bit("ready again", 1'b1, ready);
        check_bit("gate again", 1'b1, gate);
        check_bit("no fault", 1'b0, fault);
    endtask : t_recover
    task automatic final_report();
        $display("checks %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        t_reset();
        t_power_up();
        t_test_pulse();
        t_stop_trip();
        t_restart();
        t_release_trip();
        t_double_trip();
        t_recover();
        final_report();
    end
endmodule : safe_torque_off_interlock_tb

//--- stoi_filter.sv
// Purpose: Synchronise one request pin, drop short low test pulses,
//          sample on the scan tick and delay the result
// Assumes: Pin is asynchronous to clk_i
// Notes:   Low must persist beyond the pulse window to count
`timescale 1ns/10ps
module stoi_filter
    import stoi_pkg::*;
#(
    parameter int unsigned DELAY_TICKS = 1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic tick_i,
    output logic      level_o
);
    logic              s1_q;
    logic              s2_q;
    logic [CNT_W-1:0]  low_cnt_q;
    logic              filt_q;
    logic [TICK_W-1:0] dly_q;

    // Two-stage synchroniser; only s2_q is used beyond here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
        end
    end

    // Count low time; a low shorter than the pulse window is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_q <= '0;
            filt_q    <= 1'b0;
        end else if (s2_q) begin
            low_cnt_q <= '0;
            filt_q    <= 1'b1;
        end else if (low_cnt_q < CNT_W'(PULSE_CYC)) begin
            low_cnt_q <= low_cnt_q + CNT_W'(1);
        end else begin
            filt_q    <= 1'b0;
        end
    end

    // Sample on the scan tick, then shift out after the delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q <= '0;
        end else if (tick_i) begin
            dly_q <= {dly_q[TICK_W-2:0], filt_q};
        end
    end

    assign level_o = dly_q[DELAY_TICKS-1];
endmodule : stoi_filter

//--- stoi_interlock.sv
// Purpose: Two-channel safe torque-off interlock with feedback relay
// Assumes: Request pins are asynchronous, restart clear is a pulse
// Notes:   Only the stop channel gates the pulse amplifier supply; both channels gate the gate enable
`timescale 1ns/10ps
module stoi_interlock
    import stoi_pkg::*;
#(
    // Scan tick period in clocks; the default is the 1 ms scan
    parameter int unsigned SCAN_TICK_CYC = SCAN_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic safe_stop_request_input_i,
    input  wire logic power_stage_release_input_i,
    input  wire logic restart_clear_i,
    output logic      amp_supply_on_o,
    output logic      gate_enable_o,
    output logic      stop_feedback_relay_o,
    output logic      power_stage_ready_o,
    output logic      restart_inhibit_o,
    output logic      channel_fault_o
);
    logic [CNT_W-1:0]  scan_cnt_q;
    logic              tick_q;
    logic              stop_ok;
    logic              rel_ok;
    logic              inhibit_q;
    logic [TICK_W-1:0] relay_cnt_q;
    logic              relay_q;
    logic              amp_q;
    logic              gate_q;
    logic              ready_q;
    logic              fault_q;
    logic              clr_s1_q;
    logic              clr_s2_q;
    logic              clr_s3_q;
    logic              clr_rise;

    // Free-running 1 ms scan tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (scan_cnt_q == CNT_W'(SCAN_TICK_CYC - 1)) begin
            scan_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            scan_cnt_q <= scan_cnt_q + CNT_W'(1);
            tick_q     <= 1'b0;
        end
    end

    // Stop-request channel with its short internal delay
    stoi_filter #(
        .DELAY_TICKS (STOP_TICKS)
    ) u_stop (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (safe_stop_request_input_i),
        .tick_i  (tick_q),
        .level_o (stop_ok)
    );

    // Release channel with its longer internal delay
    stoi_filter #(
        .DELAY_TICKS (REL_TICKS)
    ) u_rel (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (power_stage_release_input_i),
        .tick_i  (tick_q),
        .level_o (rel_ok)
    );

    // Synchronise the restart clear and take its rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clr_s1_q <= 1'b0;
            clr_s2_q <= 1'b0;
            clr_s3_q <= 1'b0;
        end else begin
            clr_s1_q <= restart_clear_i;
            clr_s2_q <= clr_s1_q;
            clr_s3_q <= clr_s2_q;
        end
    end
    assign clr_rise = clr_s2_q & ~clr_s3_q;

    // Restart inhibit: set by a stop request, which wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inhibit_q <= 1'b1;
        end else if (!stop_ok) begin
            inhibit_q <= 1'b1;
        end else if (clr_rise) begin
            inhibit_q <= 1'b0;
        end
    end

    // Each channel blocks on its own; amp supply is the stop channel,
    // gate enable needs release too, so one stuck path still stops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_q   <= 1'b0;
            gate_q  <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            amp_q   <= stop_ok;
            gate_q  <= stop_ok & rel_ok & amp_q;
            ready_q <= stop_ok & rel_ok & ~inhibit_q;
        end
    end

    // Relay closes after its operating delay only with both tripped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            relay_cnt_q <= '0;
            relay_q     <= 1'b0;
        end else if (stop_ok || rel_ok) begin
            relay_cnt_q <= '0;
            relay_q     <= 1'b0;
        end else if (tick_q) begin
            if (relay_cnt_q == TICK_W'(RELAY_TICKS - 1)) begin
                relay_q <= 1'b1;
            end else begin
                relay_cnt_q <= relay_cnt_q + TICK_W'(1);
            end
        end
    end

    // Cross-check: gate drive with the amp supply off means a fault;
    // sticky until reset so it is seen at the next request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
        end else if (gate_q && !amp_q) begin
            fault_q <= 1'b1;
        end
    end

    assign amp_supply_on_o       = amp_q;
    assign gate_enable_o         = gate_q & amp_q;
    assign stop_feedback_relay_o = relay_q;
    assign power_stage_ready_o   = ready_q;
    assign restart_inhibit_o     = inhibit_q;
    assign channel_fault_o       = fault_q;

    // Checks
    property p_stop_cuts_amp;
        @(posedge clk_i) disable iff (rst_i)
        !stop_ok |=> !amp_q;
    endproperty
    a_stop_cuts_amp: assert property (p_stop_cuts_amp)
        else $error("amp supply stayed on under stop request");

    property p_either_blocks;
        @(posedge clk_i) disable iff (rst_i)
        (!stop_ok || !rel_ok) |=> !gate_enable_o;
    endproperty
    a_either_blocks: assert property (p_either_blocks)
        else $error("gate drive with a channel low");

    property p_stop_low_amp;
        @(posedge clk_i) disable iff (rst_i)
        amp_q |-> $past(stop_ok);
    endproperty
    a_stop_low_amp: assert property (p_stop_low_amp)
        else $error("amp supply without stop channel high");

    property p_relay_both;
        @(posedge clk_i) disable iff (rst_i)
        relay_q |-> $past(!stop_ok && !rel_ok);
    endproperty
    a_relay_both: assert property (p_relay_both)
        else $error("relay closed without both channels tripped");

    property p_one_channel;
        @(posedge clk_i) disable iff (rst_i)
        (stop_ok && !rel_ok) |=> !relay_q && !gate_q;
    endproperty
    a_one_channel: assert property (p_one_channel)
        else $error("one-channel trip closed relay or drove gate");

    property p_ready;
        @(posedge clk_i) disable iff (rst_i)
        ready_q |-> $past(stop_ok && rel_ok && !inhibit_q);
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready without both inputs and cleared inhibit");

    property p_inhibit_set;
        @(posedge clk_i) disable iff (rst_i)
        !stop_ok |=> inhibit_q;
    endproperty
    a_inhibit_set: assert property (p_inhibit_set)
        else $error("restart inhibit not set by stop request");

    property p_tick_period;
        @(posedge clk_i) disable iff (rst_i)
        tick_q |=> !tick_q [*8];
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("scan tick too frequent");

    property p_no_fault_gate;
        @(posedge clk_i) disable iff (rst_i)
        gate_enable_o |-> amp_q && !fault_q;
    endproperty
    a_no_fault_gate: assert property (p_no_fault_gate)
        else $error("gate drive while amp off or faulted");
endmodule : stoi_interlock

//--- stoi_pkg.sv
// Purpose: Shared constants for the two-channel torque-off interlock
// Assumes: 20 MHz system clock
// Notes:   Times are kept in their own units; cycle counts derive here
package stoi_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned SCAN_PERIOD_US  = 1000;
    localparam int unsigned STOP_DELAY_MS   = 2;
    localparam int unsigned REL_DELAY_MS    = 10;
    localparam int unsigned RELAY_DELAY_MS  = 10;
    localparam int unsigned PULSE_MAX_US    = 300;
    // Scan tick period in clocks (exact)
    localparam int unsigned SCAN_CYC =
        (CLK_HZ / 1_000_000) * SCAN_PERIOD_US;
    // Test pulse longer than this many clocks is a real low (least time)
    localparam int unsigned PULSE_CYC =
        ((CLK_HZ / 1_000_000) * PULSE_MAX_US);
    // Delays expressed in scan ticks
    localparam int unsigned STOP_TICKS  = STOP_DELAY_MS;
    localparam int unsigned REL_TICKS   = REL_DELAY_MS;
    localparam int unsigned RELAY_TICKS = RELAY_DELAY_MS;
    localparam int unsigned CNT_W  = 15;
    // Delay line must hold the longest channel delay in ticks
    localparam int unsigned TICK_W = REL_TICKS;
endpackage : stoi_pkg

//--- stoi_safety_ctrl.sv
// Purpose: Model of the external two-channel safety circuit
// Assumes: Commands change at the falling clock edge
// Notes:   A test pulse is a short OSSD low on the stop line
`timescale 1ns/10ps
module stoi_safety_ctrl (
    input  wire logic stop_cmd_i,
    input  wire logic release_cmd_i,
    input  wire logic test_pulse_i,
    output logic      stop_pin_o,
    output logic      release_pin_o
);
    // Request or self-test pulls the stop line low; both pins are levels
    assign stop_pin_o    = ~stop_cmd_i & ~test_pulse_i;
    assign release_pin_o = release_cmd_i;
endmodule : stoi_safety_ctrl
